// ===== logic/pcoc_consts.svh
`ifndef PCOC_CONSTS_SVH
`define PCOC_CONSTS_SVH

// ---------------------------------------------------------------
// classification bands, currents in mA (upper inclusive bounds)
// ---------------------------------------------------------------
`define PCOC_CLS0_MAX 8'd5
`define PCOC_CLS1_MAX 8'd13
`define PCOC_CLS2_MAX 8'd21
`define PCOC_CLS3_MAX 8'd31
`define PCOC_CLS4_MAX 8'd45
`define PCOC_INVALID_MA 8'd51

// ---------------------------------------------------------------
// current limits in mA
// ---------------------------------------------------------------
`define PCOC_STARTUP_LIMIT_MA 12'd420
`define PCOC_C5A_CUT_MA 12'd748
`define PCOC_C5A_LIM_MA 12'd850
`define PCOC_C5B_CUT_MA 12'd792
`define PCOC_C5B_LIM_MA 12'd900
`define PCOC_C5C_CUT_MA 12'd836
`define PCOC_C5C_LIM_MA 12'd950
`define PCOC_CLS_LOW_LIM_MA 12'd425
`define PCOC_CLS4_LIM_MA 12'd720
`define PCOC_FOLDBACK_FLOOR_MA 12'd100
`define PCOC_OVERSHOOT_MA 12'd2000
`define PCOC_CUT_NUM 12'd88
`define PCOC_CUT_DEN 12'd100

// ---------------------------------------------------------------
// foldback knees, port voltage in V
// ---------------------------------------------------------------
`define PCOC_FB_HIGH_V 8'd27
`define PCOC_FB_LOW_V 8'd10

// ---------------------------------------------------------------
// timing, 10 MHz clock
// ---------------------------------------------------------------
`define PCOC_CLK_HZ 100000000/10
`define PCOC_FAULT_US 60000
`define PCOC_STARTUP_US 60000
`define PCOC_DISC_US 350000
`define PCOC_CLASS_US 10000
`define PCOC_MARK_US 8000
`define PCOC_DECR_RATIO 16

`endif

// ===== logic/pcoc_limit_sel.sv
`timescale 1ns/1ns
`include "pcoc_consts.svh"
// maps class, phase and port voltage to limit and cut thresholds
module pcoc_limit_sel (
  // selection inputs
  input wire pcoc_pkg::pcoc_class_t cls,
  input wire logic startup,
  input wire logic class5_limit_sel_a,
  input wire logic class5_limit_sel_b,
  input wire logic [7:0] port_voltage,
  // thresholds
  output logic [11:0] limit_ma,
  output logic [11:0] cut_ma
);
  logic [11:0] base_lim; // limit before foldback
  logic [11:0] base_cut; // cut before foldback
  logic [23:0] scaled; // foldback interpolation product

  // ---------------------------------------------------------------
  // base thresholds
  // ---------------------------------------------------------------
  always_comb begin
    base_lim = `PCOC_CLS_LOW_LIM_MA;
    base_cut = 12'((24'(`PCOC_CLS_LOW_LIM_MA) * 24'(`PCOC_CUT_NUM)) / 24'(`PCOC_CUT_DEN));
    if (startup) begin
      base_lim = `PCOC_STARTUP_LIMIT_MA;
      base_cut = `PCOC_STARTUP_LIMIT_MA;
    end else if (cls == pcoc_pkg::PCOC_C5) begin
      // inputs are active low: grounded pin selects
      if (!class5_limit_sel_a && !class5_limit_sel_b) begin
        base_lim = `PCOC_C5C_LIM_MA;
        base_cut = `PCOC_C5C_CUT_MA;
      end else if (!class5_limit_sel_b) begin
        base_lim = `PCOC_C5B_LIM_MA;
        base_cut = `PCOC_C5B_CUT_MA;
      end else begin
        base_lim = `PCOC_C5A_LIM_MA;
        base_cut = `PCOC_C5A_CUT_MA;
      end
    end else if (cls == pcoc_pkg::PCOC_C4) begin
      base_lim = `PCOC_CLS4_LIM_MA;
      base_cut = 12'((24'(`PCOC_CLS4_LIM_MA) * 24'(`PCOC_CUT_NUM)) / 24'(`PCOC_CUT_DEN));
    end
  end

  // ---------------------------------------------------------------
  // foldback: linear between floor and base across the knees
  // ---------------------------------------------------------------
  always_comb begin
    scaled = 24'h000000;
    if (port_voltage >= `PCOC_FB_HIGH_V) begin
      limit_ma = base_lim;
      cut_ma = base_cut;
    end else if (port_voltage < `PCOC_FB_LOW_V) begin
      limit_ma = `PCOC_FOLDBACK_FLOOR_MA;
      cut_ma = `PCOC_FOLDBACK_FLOOR_MA;
    end else begin
      // interpolation keeps the mosfet dissipation bounded
      scaled = 24'(base_lim - `PCOC_FOLDBACK_FLOOR_MA) * 24'(port_voltage - `PCOC_FB_LOW_V)
               / 24'(`PCOC_FB_HIGH_V - `PCOC_FB_LOW_V);
      limit_ma = `PCOC_FOLDBACK_FLOOR_MA + scaled[11:0];
      cut_ma = 12'((24'(limit_ma) * 24'(`PCOC_CUT_NUM)) / 24'(`PCOC_CUT_DEN));
    end
  end
endmodule

// ===== logic/pcoc_pkg.sv
package pcoc_pkg;
  // port state machine, one-hot
  typedef enum logic [8:0] {
    PCOC_IDLE    = 9'h001,
    PCOC_DETECT  = 9'h002,
    PCOC_CLASS1  = 9'h004,
    PCOC_MARK1   = 9'h008,
    PCOC_CLASS2  = 9'h010,
    PCOC_MARK2   = 9'h020,
    PCOC_STARTUP = 9'h040,
    PCOC_NORMAL  = 9'h080,
    PCOC_COOL    = 9'h100
  } pcoc_state_t;

  // class result
  typedef enum logic [2:0] {
    PCOC_C0 = 3'h0, PCOC_C1 = 3'h1, PCOC_C2 = 3'h2, PCOC_C3 = 3'h3,
    PCOC_C4 = 3'h4, PCOC_C5 = 3'h5, PCOC_CINV = 3'h7
  } pcoc_class_t;

  // analogue measurements presented to the logic
  typedef struct packed {
    logic [7:0] classification_current;
    logic [11:0] sensed_load_current;
    logic [7:0] port_voltage;
  } pcoc_meas_t;

  // controls to the analogue front end
  typedef struct packed {
    logic probe_class;
    logic probe_mark;
    logic detect_on;
    logic port_on;
    logic fast_pulldown;
    logic [11:0] current_limit_threshold;
    logic [11:0] overcurrent_cut_threshold;
  } pcoc_ctrl_t;
endpackage

// ===== logic/pcoc_port_ctrl.sv
`timescale 1ns/1ns
`include "pcoc_consts.svh"
// Function
// - map class current to classes 0-4 by bands
// - class 5 above class 4 band when enabled
// - both selects high disables class 5
// - class 5 limits from the select pins
// - second class event only for 4 or 5
// - mark events after each of the two class events
// - powered entry clears timers; startup then normal
// - fast pulldown on overshoot above limit
// - normal cut threshold about 88 percent limit
// - fault counter increments over applicable threshold
// - fault counter decrements slower when below
// - counter at limit powers port down
// - after fault, repower only at zero count
// - normal thresholds follow class result
// - startup uses fixed 420 mA limit
// - foldback below 27 V, floor below 10 V
// - invalid class without class 5 returns idle
// - dc disconnect after low current persists
module pcoc_port_ctrl #(
  parameter int FAULT_CYCLES = (`PCOC_FAULT_US * (`PCOC_CLK_HZ / 1000000)),
  parameter int STARTUP_CYCLES = (`PCOC_STARTUP_US * (`PCOC_CLK_HZ / 1000000)),
  parameter int DISC_CYCLES = (`PCOC_DISC_US * (`PCOC_CLK_HZ / 1000000)),
  parameter int CLASS_CYCLES = (`PCOC_CLASS_US * (`PCOC_CLK_HZ / 1000000)),
  parameter int MARK_CYCLES = (`PCOC_MARK_US * (`PCOC_CLK_HZ / 1000000)),
  parameter int DECR_RATIO = `PCOC_DECR_RATIO
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration pins, asynchronous
  input wire logic class5_limit_sel_a,
  input wire logic class5_limit_sel_b,
  input wire logic dc_disconnect_sel,
  // analogue front end results, asynchronous
  input wire logic detect_done,
  input wire logic detect_valid,
  input wire logic below_dc_disconnect_threshold,
  input wire pcoc_pkg::pcoc_meas_t meas,
  // front end controls
  output pcoc_pkg::pcoc_ctrl_t ctrl,
  // status
  output pcoc_pkg::pcoc_class_t class_result,
  output logic overcurrent_fault
);
  localparam int CW = 24; // width of the shared timers

  // synchronised inputs
  logic [1:0] sel_a_s, sel_b_s, dcsel_s, ddone_s, dvalid_s, below_s;
  pcoc_pkg::pcoc_meas_t meas_s1, meas_s2;
  // latched configuration
  logic c5_en_r, dc_mode_r, sel_a_r, sel_b_r, cfg_taken_r;
  // state
  pcoc_pkg::pcoc_state_t state_r, state_nxt;
  pcoc_pkg::pcoc_class_t cls_r;
  pcoc_pkg::pcoc_class_t cls_now;
  logic [CW-1:0] step_r; // phase timer
  logic [CW-1:0] fault_r; // overcurrent fault counter
  logic [CW-1:0] disc_r; // disconnect timer
  logic [7:0] decr_div_r; // slows the fault counter decrement
  logic fault_off_r; // port was shut by overcurrent
  logic [11:0] lim_ma, cut_ma;
  logic over, powered, entering_power;

  // ---------------------------------------------------------------
  // two-flop synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_a_s <= 2'h3;
      sel_b_s <= 2'h3;
      dcsel_s <= 2'h0;
      ddone_s <= 2'h0;
      dvalid_s <= 2'h0;
      below_s <= 2'h0;
      meas_s1 <= '0;
      meas_s2 <= '0;
    end else begin
      sel_a_s <= {sel_a_s[0], class5_limit_sel_a};
      sel_b_s <= {sel_b_s[0], class5_limit_sel_b};
      dcsel_s <= {dcsel_s[0], dc_disconnect_sel};
      ddone_s <= {ddone_s[0], detect_done};
      dvalid_s <= {dvalid_s[0], detect_valid};
      below_s <= {below_s[0], below_dc_disconnect_threshold};
      meas_s1 <= meas;
      meas_s2 <= meas_s1;
    end
  end

  // ---------------------------------------------------------------
  // configuration capture once after reset release
  // ---------------------------------------------------------------
  // pins are only read after the synchroniser has filled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_taken_r <= 1'b0;
      c5_en_r <= 1'b0;
      dc_mode_r <= 1'b0;
      sel_a_r <= 1'b1;
      sel_b_r <= 1'b1;
    end else if (!cfg_taken_r && state_r == pcoc_pkg::PCOC_IDLE && step_r == CW'(2)) begin
      cfg_taken_r <= 1'b1;
      c5_en_r <= !(sel_a_s[1] && sel_b_s[1]);
      dc_mode_r <= dcsel_s[1];
      sel_a_r <= sel_a_s[1];
      sel_b_r <= sel_b_s[1];
    end
  end

  // ---------------------------------------------------------------
  // class decode
  // ---------------------------------------------------------------
  // guard bands resolve to the lower class
  always_comb begin
    if (meas_s2.classification_current <= `PCOC_CLS0_MAX + 8'd2) cls_now = pcoc_pkg::PCOC_C0;
    else if (meas_s2.classification_current <= `PCOC_CLS1_MAX + 8'd2) cls_now = pcoc_pkg::PCOC_C1;
    else if (meas_s2.classification_current <= `PCOC_CLS2_MAX + 8'd3) cls_now = pcoc_pkg::PCOC_C2;
    else if (meas_s2.classification_current <= `PCOC_CLS3_MAX + 8'd3) cls_now = pcoc_pkg::PCOC_C3;
    else if (meas_s2.classification_current <= `PCOC_CLS4_MAX) cls_now = pcoc_pkg::PCOC_C4;
    else if (c5_en_r) cls_now = pcoc_pkg::PCOC_C5;
    else if (meas_s2.classification_current < `PCOC_INVALID_MA) cls_now = pcoc_pkg::PCOC_C4;
    else cls_now = pcoc_pkg::PCOC_CINV;
  end

  // ---------------------------------------------------------------
  // threshold selection
  // ---------------------------------------------------------------
  pcoc_limit_sel u_limit_sel (
    .cls(cls_r),
    .startup(state_nxt == pcoc_pkg::PCOC_STARTUP),
    .class5_limit_sel_a(sel_a_r),
    .class5_limit_sel_b(sel_b_r),
    .port_voltage(meas_s2.port_voltage),
    .limit_ma(lim_ma),
    .cut_ma(cut_ma)
  );

  assign powered = (state_r == pcoc_pkg::PCOC_STARTUP) || (state_r == pcoc_pkg::PCOC_NORMAL);
  // lookup runs on the next state, so the registered copy fits this one and no loop forms
  assign over = (state_r == pcoc_pkg::PCOC_STARTUP) ? (meas_s2.sensed_load_current > ctrl.current_limit_threshold) :
                (meas_s2.sensed_load_current > ctrl.overcurrent_cut_threshold);
  assign entering_power = (state_r != pcoc_pkg::PCOC_STARTUP) && (state_nxt == pcoc_pkg::PCOC_STARTUP);

  // ---------------------------------------------------------------
  // state sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pcoc_pkg::PCOC_IDLE: begin
        // cool-down gate: no power until counter drained
        if (cfg_taken_r && fault_r == '0) state_nxt = pcoc_pkg::PCOC_DETECT;
      end
      pcoc_pkg::PCOC_DETECT: begin
        if (ddone_s[1]) state_nxt = dvalid_s[1] ? pcoc_pkg::PCOC_CLASS1 : pcoc_pkg::PCOC_IDLE;
      end
      pcoc_pkg::PCOC_CLASS1: begin
        if (step_r == CW'(CLASS_CYCLES - 1)) begin
          if (cls_now == pcoc_pkg::PCOC_CINV) state_nxt = pcoc_pkg::PCOC_IDLE;
          else if (cls_now == pcoc_pkg::PCOC_C4 || cls_now == pcoc_pkg::PCOC_C5) begin
            state_nxt = pcoc_pkg::PCOC_MARK1;
          end else state_nxt = pcoc_pkg::PCOC_STARTUP;
        end
      end
      pcoc_pkg::PCOC_MARK1: begin
        if (step_r == CW'(MARK_CYCLES - 1)) state_nxt = pcoc_pkg::PCOC_CLASS2;
      end
      pcoc_pkg::PCOC_CLASS2: begin
        if (step_r == CW'(CLASS_CYCLES - 1)) begin
          state_nxt = (cls_now == pcoc_pkg::PCOC_CINV) ? pcoc_pkg::PCOC_IDLE : pcoc_pkg::PCOC_MARK2;
        end
      end
      pcoc_pkg::PCOC_MARK2: begin
        if (step_r == CW'(MARK_CYCLES - 1)) state_nxt = pcoc_pkg::PCOC_STARTUP;
      end
      pcoc_pkg::PCOC_STARTUP: begin
        if (fault_r >= CW'(FAULT_CYCLES - 1) && over) state_nxt = pcoc_pkg::PCOC_COOL;
        else if (step_r == CW'(STARTUP_CYCLES - 1)) state_nxt = pcoc_pkg::PCOC_NORMAL;
      end
      pcoc_pkg::PCOC_NORMAL: begin
        if (fault_r >= CW'(FAULT_CYCLES - 1) && over) state_nxt = pcoc_pkg::PCOC_COOL;
        else if (dc_mode_r && disc_r >= CW'(DISC_CYCLES - 1) && below_s[1]) begin
          state_nxt = pcoc_pkg::PCOC_IDLE;
        end
      end
      pcoc_pkg::PCOC_COOL: begin
        if (fault_r == '0) state_nxt = pcoc_pkg::PCOC_IDLE;
      end
      default: state_nxt = pcoc_pkg::PCOC_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) state_r <= pcoc_pkg::PCOC_IDLE;
    else state_r <= state_nxt;
  end

  // phase timer restarts on every state change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) step_r <= '0;
    else if (state_nxt != state_r) step_r <= '0;
    else if (step_r != {CW{1'b1}}) step_r <= step_r + CW'(1);
  end

  // class result held from the last class event
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cls_r <= pcoc_pkg::PCOC_C0;
    else if ((state_r == pcoc_pkg::PCOC_CLASS1 || state_r == pcoc_pkg::PCOC_CLASS2)
             && step_r == CW'(CLASS_CYCLES - 1)) cls_r <= cls_now;
  end

  // ---------------------------------------------------------------
  // overcurrent fault counter
  // ---------------------------------------------------------------
  // decrement runs at 1/DECR_RATIO so short bursts accumulate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) decr_div_r <= 8'h00;
    else if (decr_div_r == 8'(DECR_RATIO - 1)) decr_div_r <= 8'h00;
    else decr_div_r <= decr_div_r + 8'h01;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) fault_r <= '0;
    else if (entering_power) fault_r <= '0;
    else if (powered && over) begin
      if (fault_r < CW'(FAULT_CYCLES)) fault_r <= fault_r + CW'(1);
    end else if (decr_div_r == 8'(DECR_RATIO - 1) && fault_r != '0) begin
      fault_r <= fault_r - CW'(1);
    end
  end

  // fault flag: set wins over the clear on a fresh shutdown
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) fault_off_r <= 1'b0;
    else if (state_nxt == pcoc_pkg::PCOC_COOL && state_r != pcoc_pkg::PCOC_COOL) fault_off_r <= 1'b1;
    else if (entering_power) fault_off_r <= 1'b0;
  end

  // disconnect timer: counts while current stays low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) disc_r <= '0;
    else if (entering_power || !below_s[1]) disc_r <= '0;
    else if (state_r == pcoc_pkg::PCOC_NORMAL && disc_r != {CW{1'b1}}) disc_r <= disc_r + CW'(1);
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl.probe_class <= state_nxt == pcoc_pkg::PCOC_CLASS1 || state_nxt == pcoc_pkg::PCOC_CLASS2;
      ctrl.probe_mark <= state_nxt == pcoc_pkg::PCOC_MARK1 || state_nxt == pcoc_pkg::PCOC_MARK2;
      ctrl.detect_on <= state_nxt == pcoc_pkg::PCOC_DETECT;
      ctrl.port_on <= state_nxt == pcoc_pkg::PCOC_STARTUP || state_nxt == pcoc_pkg::PCOC_NORMAL;
      // overshoot margin above limit triggers the pulldown
      ctrl.fast_pulldown <= powered &&
                            ({1'b0, meas_s2.sensed_load_current} > {1'b0, lim_ma} + {1'b0, `PCOC_OVERSHOOT_MA});
      ctrl.current_limit_threshold <= lim_ma;
      ctrl.overcurrent_cut_threshold <= cut_ma;
    end
  end

  assign class_result = cls_r;
  assign overcurrent_fault = fault_off_r;
endmodule

// ===== testbench/pcoc_pd_model.sv
`timescale 1ns/1ns
// powered device on the port, as seen through the analogue front end
module pcoc_pd_model (
  // clock
  input wire logic clock,
  // controls from the port controller
  input wire pcoc_pkg::pcoc_ctrl_t ctrl,
  // device personality, set by the bench
  input wire logic sig_ok,
  input wire logic [3:0] det_delay,
  input wire logic [7:0] class_ma,
  input wire logic [11:0] load_ma,
  input wire logic [7:0] volt,
  // front end results
  output logic detect_done,
  output logic detect_valid,
  output pcoc_pkg::pcoc_meas_t meas
);
  logic [3:0] det_cnt_r = 4'h0; // detection settle time, slow or prompt
  logic toggle_r = 1'b0; // wanders between detections

  // ------------------------------------------------
  // detection answer
  // ------------------------------------------------
  // count while the probe runs, restart when it stops
  always_ff @(posedge clock) begin
    toggle_r <= ~toggle_r;
    if (ctrl.detect_on) begin
      det_cnt_r <= (det_cnt_r == det_delay) ? det_cnt_r : det_cnt_r + 4'h1;
    end
    else begin
      det_cnt_r <= 4'h0;
    end
  end
  assign detect_done = ctrl.detect_on && (det_cnt_r == det_delay);
  // valid means nothing outside a finished detection
  assign detect_valid = detect_done ? sig_ok : toggle_r;

  // ------------------------------------------------
  // currents and voltage
  // ------------------------------------------------
  // class current only flows while a class probe is applied
  assign meas.classification_current = ctrl.probe_class ? class_ma : 8'h00;
  // load current only flows with the port switched on
  assign meas.sensed_load_current = ctrl.port_on ? load_ma : 12'h000;
  assign meas.port_voltage = volt;
endmodule

// ===== testbench/pcoc_port_ctrl_asserts.sv
`timescale 1ns/1ns
// watches the port controller pins for sequencing and limit relations
module pcoc_port_ctrl_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration and front end inputs
  input wire logic class5_limit_sel_a,
  input wire logic class5_limit_sel_b,
  input wire logic dc_disconnect_sel,
  input wire logic detect_done,
  input wire logic detect_valid,
  input wire logic below_dc_disconnect_threshold,
  input wire pcoc_pkg::pcoc_meas_t meas,
  // outputs
  input wire pcoc_pkg::pcoc_ctrl_t ctrl,
  input wire pcoc_pkg::pcoc_class_t class_result,
  input wire logic overcurrent_fault
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------
  // sequencing
  // ------------------------------------------------
  property p_probe_apart;
    !(ctrl.probe_class && ctrl.probe_mark);
  endproperty
  a_probe_apart: assert property (p_probe_apart) else $error("class and mark probes overlap");
  property p_power_alone;
    ctrl.port_on |-> !ctrl.detect_on && !ctrl.probe_class && !ctrl.probe_mark;
  endproperty
  a_power_alone: assert property (p_power_alone) else $error("probe active while powered");
  property p_class_hold;
    $rose(ctrl.probe_class) |-> ctrl.probe_class [*8];
  endproperty
  a_class_hold: assert property (p_class_hold) else $error("class probe too short");
  property p_mark_needs_c4;
    $rose(ctrl.probe_mark) |-> class_result inside {pcoc_pkg::PCOC_C4, pcoc_pkg::PCOC_C5};
  endproperty
  a_mark_needs_c4: assert property (p_mark_needs_c4) else $error("mark for low class");
  property p_mark_then_next;
    $fell(ctrl.probe_mark) |-> ctrl.probe_class || ctrl.port_on;
  endproperty
  a_mark_then_next: assert property (p_mark_then_next) else $error("mark not followed");
  property p_no_invalid_power;
    $rose(ctrl.port_on) |-> class_result != pcoc_pkg::PCOC_CINV;
  endproperty
  a_no_invalid_power: assert property (p_no_invalid_power) else $error("invalid class powered");

  // ------------------------------------------------
  // limits and faults
  // ------------------------------------------------
  property p_start_limit;
    $rose(ctrl.port_on) && meas.port_voltage >= 8'd27 && $past(meas.port_voltage, 4) >= 8'd27
      |-> ctrl.current_limit_threshold == 12'd420;
  endproperty
  a_start_limit: assert property (p_start_limit) else $error("startup limit wrong");
  property p_c5_cut;
    ctrl.current_limit_threshold inside {12'd850, 12'd900, 12'd950} |-> ctrl.overcurrent_cut_threshold ==
      (ctrl.current_limit_threshold == 12'd850 ? 12'd748 : ctrl.current_limit_threshold == 12'd900 ? 12'd792 : 12'd836);
  endproperty
  a_c5_cut: assert property (p_c5_cut) else $error("class 5 cut mismatch");
  property p_fault_off;
    $rose(overcurrent_fault) |-> ##[0:1] !ctrl.port_on;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("port on after fault");
  property p_fold_floor;
    ctrl.port_on && $past(ctrl.port_on, 5) && meas.port_voltage < 8'd10 && $past(meas.port_voltage, 5) < 8'd10
      |-> ctrl.current_limit_threshold == 12'd100;
  endproperty
  a_fold_floor: assert property (p_fold_floor) else $error("foldback floor wrong");

  // main scenarios reached
  c_powered: cover property ($rose(ctrl.port_on));
  c_fault: cover property ($rose(overcurrent_fault));
  c_mark: cover property ($rose(ctrl.probe_mark));
  c_pulldown: cover property ($rose(ctrl.fast_pulldown));
endmodule

bind pcoc_port_ctrl pcoc_port_ctrl_asserts u_pcoc_port_ctrl_asserts (
  .clock(clock), .rst_n(rst_n), .class5_limit_sel_a(class5_limit_sel_a), .class5_limit_sel_b(class5_limit_sel_b),
  .dc_disconnect_sel(dc_disconnect_sel), .detect_done(detect_done), .detect_valid(detect_valid),
  .below_dc_disconnect_threshold(below_dc_disconnect_threshold), .meas(meas), .ctrl(ctrl),
  .class_result(class_result), .overcurrent_fault(overcurrent_fault)
);

// ===== testbench/test_pse_class_overcurrent_control.sv
`timescale 1ns/1ns
module test_pse_class_overcurrent_control;
  // ------------------------------------------------
  // bench signals
  // ------------------------------------------------
  localparam int FC = 50; // shortened fault window
  localparam int SC = 100; // shortened startup
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sel_a = 1'b1; // unconnected pins read high
  logic sel_b = 1'b1;
  logic dc_sel = 1'b0;
  logic low_cur = 1'b0;
  logic sig_ok = 1'b1;
  logic [3:0] det_delay = 4'h2;
  logic [7:0] class_ma = 8'h00;
  logic [11:0] load_ma = 12'h000;
  logic [7:0] volt = 8'h30;
  logic detect_done;
  logic detect_valid;
  pcoc_pkg::pcoc_meas_t meas;
  pcoc_pkg::pcoc_ctrl_t ctrl;
  pcoc_pkg::pcoc_class_t class_result;
  logic overcurrent_fault;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h9697;
  int cls;
  int lim;
  int took;
  int tab[11] = '{3, 6, 10, 14, 18, 23, 28, 33, 40, 48, 60};

  pcoc_port_ctrl #(.FAULT_CYCLES(FC), .STARTUP_CYCLES(SC), .DISC_CYCLES(100), .CLASS_CYCLES(20),
    .MARK_CYCLES(20), .DECR_RATIO(4)) u_pcoc_port_ctrl (
    .clock(clock), .rst_n(rst_n), .class5_limit_sel_a(sel_a), .class5_limit_sel_b(sel_b),
    .dc_disconnect_sel(dc_sel), .detect_done(detect_done), .detect_valid(detect_valid),
    .below_dc_disconnect_threshold(low_cur), .meas(meas), .ctrl(ctrl), .class_result(class_result),
    .overcurrent_fault(overcurrent_fault));
  pcoc_pd_model u_pcoc_pd_model (.clock(clock), .ctrl(ctrl), .sig_ok(sig_ok), .det_delay(det_delay),
    .class_ma(class_ma), .load_ma(load_ma), .volt(volt), .detect_done(detect_done),
    .detect_valid(detect_valid), .meas(meas));
  always #50 clock = ~clock;
  // ------------------------------------------------
  // reference model and helpers
  // ------------------------------------------------
  // guard bands settle on the lower class
  function automatic int exp_class(input int ma, input logic c5);
    if (ma <= 7) return 0;
    if (ma <= 15) return 1;
    if (ma <= 24) return 2;
    if (ma <= 34) return 3;
    if (ma <= 45) return 4;
    if (ma <= 50) return c5 ? 5 : 4;
    return c5 ? 5 : 7;
  endfunction
  function automatic int exp_lim(input int c, input logic a, input logic b);
    if (c < 4) return 425;
    if (c == 4) return 720;
    return (!a && b) ? 850 : (a && !b) ? 900 : 950;
  endfunction
  function automatic int exp_cut(input int l);
    if (l >= 850) return (l == 850) ? 748 : (l == 900) ? 792 : 836;
    return l * 88 / 100;
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return overcurrent_fault;
      1: return ctrl.fast_pulldown;
      2: return !ctrl.port_on;
      default: return ctrl.detect_on;
    endcase
  endfunction
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // n edges on, then just past the last
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask
  task automatic wait_sig(input int w, input int limit);
    took = 0;
    while (sig(w) !== 1'b1 && took < limit) begin
      tick(1);
      took++;
    end
  endtask
  // reset with new straps, then run up to normal power unless the class is invalid
  task automatic power_up(input logic [7:0] ma, input logic a, input logic b, input logic d);
    logic marked;
    rst_n = 1'b0;
    sel_a = a;
    sel_b = b;
    dc_sel = d;
    class_ma = ma;
    load_ma = 12'h000;
    low_cur = 1'b0;
    volt = 8'h30;
    cls = exp_class(ma, !(a && b));
    lim = exp_lim(cls, a, b);
    tick(10);
    rst_n = 1'b1;
    marked = 1'b0;
    took = 0;
    while (ctrl.port_on !== 1'b1 && took < 400) begin
      marked = marked | (ctrl.probe_mark === 1'b1);
      tick(1);
      took++;
    end
    check("second event", 12'(cls == 4 || cls == 5), 12'(marked));
    check("class", 12'(cls), 12'(class_result));
    check("port on", 12'(cls != 7), 12'(ctrl.port_on));
    if (cls != 7) begin
      check("startup limit", 12'd420, ctrl.current_limit_threshold);
      tick(SC + 5);
      check("normal limit", 12'(lim), ctrl.current_limit_threshold);
      check("cut", 12'(exp_cut(lim)), ctrl.overcurrent_cut_threshold);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end
    else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 30000) begin
      bad_count++;
      $display("Error run length expected finish seen hang");
      results();
    end
  end

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    foreach (tab[i]) begin
      power_up(8'(tab[i]), 1'b1, 1'b1, 1'b0);
    end
    repeat (4) begin
      power_up(8'($random(seed) & 63), 1'b1, 1'b1, 1'b0);
    end
    $display("test class bands done");
    for (int i = 0; i < 3; i++) begin
      power_up(8'd60, i[0], i[1], 1'b0);
    end
    power_up(8'd48, 1'b0, 1'b1, 1'b0);
    $display("test class 5 done");
    power_up(8'd40, 1'b1, 1'b1, 1'b0);
    volt = 8'h05;
    tick(6);
    check("fold limit", 12'd100, ctrl.current_limit_threshold);
    volt = 8'h30;
    tick(6);
    load_ma = 12'd2820;
    wait_sig(1, 8);
    check("pulldown", 12'd1, 12'(took < 8));
    $display("test foldback and pulldown done");
    power_up(8'd10, 1'b1, 1'b1, 1'b0);
    load_ma = 12'd500;
    wait_sig(0, 200);
    check("fault time", 12'd1, 12'(took >= FC && took <= FC + 4));
    check("port after fault", 12'd0, 12'(ctrl.port_on));
    load_ma = 12'h000;
    wait_sig(3, 400);
    check("cool down", 12'd1, 12'(took >= FC * 2 && took < 400));
    power_up(8'd10, 1'b1, 1'b1, 1'b0);
    load_ma = 12'd500;
    tick(30);
    load_ma = 12'd100;
    tick(30);
    load_ma = 12'd500;
    wait_sig(0, 200);
    check("burst fault", 12'd1, 12'(took <= FC - 15));
    $display("test overcurrent done");
    power_up(8'd10, 1'b1, 1'b1, 1'b0);
    low_cur = 1'b1;
    tick(150);
    check("no dc mode", 12'd1, 12'(ctrl.port_on));
    power_up(8'd10, 1'b1, 1'b1, 1'b1);
    low_cur = 1'b1;
    wait_sig(2, 300);
    check("disconnect", 12'd1, 12'(took >= 95 && took < 120));
    sig_ok = 1'b0;
    tick(100);
    check("bad signature", 12'd0, 12'(ctrl.port_on));
    $display("test disconnect done");
    results();
  end
endmodule
